// ==== perf_counter_pkg.sv ====
// Constants shared by the fixed and general-purpose performance counters
`default_nettype none
package perf_counter_pkg;

	// Widths
	localparam int CNT_W  = 64;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 64;

	// Register addresses
	localparam logic [11:0] RETIRED_INSTRUCTION_COUNT_ADDR      = 12'h309;
	localparam logic [11:0] UNHALTED_CORE_CYCLE_COUNT_ADDR      = 12'h30A;
	localparam logic [11:0] UNHALTED_REFERENCE_CYCLE_COUNT_ADDR = 12'h30B;
	localparam logic [11:0] UNHALTED_BUS_CYCLE_COUNT_ADDR       = 12'h30C;
	localparam logic [11:0] EVENT_SELECT_ADDR                   = 12'h186;
	localparam logic [11:0] GENERAL_COUNT_ADDR                  = 12'h0C1;

	// Event select field positions
	localparam int EVSEL_CODE_LSB  = 0;
	localparam int EVSEL_UMASK_LSB = 8;
	localparam int EVSEL_EN_BIT    = 22;
	localparam int EVSEL_W         = 23;

	// Event codes and unit masks
	localparam logic [7:0] EV_LOAD_BLOCK        = 8'h03;
	localparam logic [7:0] UM_WAIT_STORE_ADDR   = 8'h02;
	localparam logic [7:0] UM_WAIT_STORE_VALUE  = 8'h04;
	localparam logic [7:0] UM_OVERLAP_STORE     = 8'h08;
	localparam logic [7:0] EV_INST_RETIRED      = 8'hC0;
	localparam logic [7:0] UM_RETIRED_VIRT_ROOT = 8'h08;
	localparam logic [7:0] EV_RENAME_STALL      = 8'hD2;
	localparam logic [7:0] UM_OTHER_SERIAL      = 8'h10;

	// Reference ticks per unhalted bus cycle
	localparam logic [3:0] REF_PER_BUS = 4'h4;

	// Values after reset
	localparam logic [63:0] CNT_RESET   = 64'h0000000000000000;
	localparam logic [22:0] EVSEL_RESET = 23'h000000;
	localparam logic [3:0]  DIV_RESET   = 4'h0;

endpackage
`default_nettype wire

// ==== perf_counters.sv ====
// Fixed-function and general-purpose performance counters with register port
// Notes on behaviour
// RULE1: Fixed counter zero counts retired instructions.
// RULE2: Count only on last micro-op retiring.
// RULE3: Keep counting during interrupts, traps, handlers.
// RULE4: Fixed counter one counts unhalted core cycles.
// RULE5: Core-cycle count follows actual core clock rate.
// RULE6: Fixed counter two counts unhalted reference cycles.
// RULE7: Halt or monitor-wait both mean halted here; core-cycle count ignores mwait_active, stops on halt_active only.
// RULE8: Reference count advances at time-stamp rate.
// RULE9: Reference count keeps fixed ratio to bus cycles.
// RULE10: Software uses selectable events on general counter.
// RULE11: Load-block umask 02H counts unknown store address.
// RULE12: Umask 04H counts unknown store data value.
// RULE13: One blocked load may count several times.
// RULE14: Umask 08H counts partially overlapping older stores.
// RULE15: Overlap also counts misaligned covered loads.
// RULE16: Retired umask 08H counts virtualization root only.
// RULE17: Event D2H umask 10H counts other serialization.
// RULE18: Counters add one; reads never disturb counts.
`default_nettype none
module perf_counters (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [11:0] addr,
	input  wire logic [63:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [63:0] rd_data,
	// Retirement strobes
	input  wire logic        uop_retire,
	input  wire logic        uop_is_last,
	input  wire logic        virt_root,
	// Core state
	input  wire logic        core_cycle,
	input  wire logic        halt_active,
	input  wire logic        mwait_active,
	input  wire logic        thermal_stop_clock,
	input  wire logic        ref_tick,
	// Pipeline event strobes
	input  wire logic        load_wait_store_addr,
	input  wire logic        load_wait_store_value,
	input  wire logic        load_overlap_partial,
	input  wire logic        load_overlap_small_misalign,
	input  wire logic        load_overlap_wide_misalign,
	input  wire logic        rename_other_serial_stall,
	// Counting status
	output logic             general_enabled
);

	// All state of the block
	typedef struct packed {
		// Fixed-function counters
		logic [63:0] retired;
		logic [63:0] core_cycles;
		logic [63:0] ref_cycles;
		logic [63:0] bus_cycles;

		// General-purpose path
		logic [63:0] general;
		logic [22:0] evsel;

		// Bus-cycle divider
		logic [3:0]  ref_div;

		// Port and status registers
		logic [63:0] rd_data;
		logic        gen_en;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// Decoded qualifying conditions
	logic        inst_done;
	logic        core_halted;
	logic        core_unhalted;
	logic        ref_unhalted;
	logic        ref_count;
	logic        bus_count;
	logic        load_overlap;
	logic        gen_count;
	logic        ev_hit;

	// Event select fields
	logic [7:0]  ev_code;
	logic [7:0]  ev_umask;
	logic        ev_enable;

	// Per-event matches feeding the general counter
	logic        hit_store_addr;
	logic        hit_store_value;
	logic        hit_overlap;
	logic        hit_retired_any;
	logic        hit_retired_root;
	logic        hit_rename;

	// Register decode, one flag per mapped address
	logic        sel_retired;
	logic        sel_core;
	logic        sel_ref;
	logic        sel_bus;
	logic        sel_evsel;
	logic        sel_general;

	// Counter values plus one, wrapping at full width; next divider value, back to zero on a bus cycle
	logic [63:0] retired_plus;
	logic [63:0] core_plus;
	logic [63:0] ref_plus;
	logic [63:0] bus_plus;
	logic [63:0] general_plus;
	logic [3:0]  div_next;

	// Read mux output, registered into rd_data
	logic [63:0] rd_select;

	// Event select fields
	assign ev_code   = state_reg.evsel[perf_counter_pkg::EVSEL_CODE_LSB +: 8];
	assign ev_umask  = state_reg.evsel[perf_counter_pkg::EVSEL_UMASK_LSB +: 8];
	assign ev_enable = state_reg.evsel[perf_counter_pkg::EVSEL_EN_BIT];

	// Address compares for the write path
	assign sel_retired = (addr == perf_counter_pkg::RETIRED_INSTRUCTION_COUNT_ADDR);
	assign sel_core    = (addr == perf_counter_pkg::UNHALTED_CORE_CYCLE_COUNT_ADDR);
	assign sel_ref     = (addr == perf_counter_pkg::UNHALTED_REFERENCE_CYCLE_COUNT_ADDR);
	assign sel_bus     = (addr == perf_counter_pkg::UNHALTED_BUS_CYCLE_COUNT_ADDR);
	assign sel_evsel   = (addr == perf_counter_pkg::EVENT_SELECT_ADDR);
	assign sel_general = (addr == perf_counter_pkg::GENERAL_COUNT_ADDR);

	// Instruction completes when its final micro-op retires
	assign inst_done = uop_retire & uop_is_last; // [RULE2] [RULE3]

	// Core cycle qualifier, paced by the real core clock strobe
	assign core_unhalted = core_cycle & ~halt_active; // [RULE4] [RULE5]

	// Either sleep instruction halts the reference count
	assign core_halted = halt_active | mwait_active; // [RULE7]

	// Reference qualifier; thermal stop-clock also blocks it
	assign ref_unhalted = ~core_halted & ~thermal_stop_clock; // [RULE6]
	assign ref_count    = ref_tick & ref_unhalted; // [RULE6] [RULE8]

	// One bus cycle per fixed number of unhalted reference ticks
	assign bus_count = ref_count
		& (state_reg.ref_div == perf_counter_pkg::REF_PER_BUS - 4'h1); // [RULE9]

	// Divider wraps after the last tick of a bus cycle
	assign div_next = bus_count ? perf_counter_pkg::DIV_RESET : state_reg.ref_div + 4'h1;

	// Increment values; wrap is silent, no overflow logic here
	assign retired_plus = state_reg.retired + 64'h1;
	assign core_plus    = state_reg.core_cycles + 64'h1;
	assign ref_plus     = state_reg.ref_cycles + 64'h1;
	assign bus_plus     = state_reg.bus_cycles + 64'h1;
	assign general_plus = state_reg.general + 64'h1;

	// Overlap covers partial writes and misaligned covered loads
	assign load_overlap = load_overlap_partial // [RULE14]
		| load_overlap_small_misalign | load_overlap_wide_misalign; // [RULE15]

	// Load-block unit mask bits, each gating its own strobe
	assign hit_store_addr  = (|(ev_umask & perf_counter_pkg::UM_WAIT_STORE_ADDR))
		& load_wait_store_addr; // [RULE11]
	assign hit_store_value = (|(ev_umask & perf_counter_pkg::UM_WAIT_STORE_VALUE))
		& load_wait_store_value; // [RULE12]
	assign hit_overlap     = (|(ev_umask & perf_counter_pkg::UM_OVERLAP_STORE))
		& load_overlap; // [RULE14] [RULE15]

	// Retirement matches, root-only or any
	assign hit_retired_any  = inst_done;
	assign hit_retired_root = inst_done & virt_root; // [RULE16]

	// Rename serialization stall match
	assign hit_rename = (|(ev_umask & perf_counter_pkg::UM_OTHER_SERIAL))
		& rename_other_serial_stall; // [RULE17]

	// General counter event match; load-block unit mask bits combine as an OR
	always_comb begin
		ev_hit = 1'b0;
		unique case (ev_code)
			perf_counter_pkg::EV_LOAD_BLOCK: begin
				// Counted per blocked cycle, so one load may add several
				ev_hit = hit_store_addr | hit_store_value | hit_overlap; // [RULE13]
			end

			perf_counter_pkg::EV_INST_RETIRED: begin
				if (ev_umask == perf_counter_pkg::UM_RETIRED_VIRT_ROOT) begin
					ev_hit = hit_retired_root; // [RULE16]
				end else begin
					ev_hit = hit_retired_any;
				end
			end

			perf_counter_pkg::EV_RENAME_STALL: begin
				ev_hit = hit_rename; // [RULE17]
			end

			default: begin
				ev_hit = 1'b0;
			end
		endcase
	end

	// Selectable events only reach the general counter
	assign gen_count = ev_enable & ev_hit;

	// Read mux; unmapped addresses return zero
	always_comb begin
		rd_select = 64'h0;
		unique case (addr)
			perf_counter_pkg::RETIRED_INSTRUCTION_COUNT_ADDR: begin
				rd_select = state_reg.retired; // [RULE18]
			end

			perf_counter_pkg::UNHALTED_CORE_CYCLE_COUNT_ADDR: begin
				rd_select = state_reg.core_cycles;
			end

			perf_counter_pkg::UNHALTED_REFERENCE_CYCLE_COUNT_ADDR: begin
				rd_select = state_reg.ref_cycles;
			end

			perf_counter_pkg::UNHALTED_BUS_CYCLE_COUNT_ADDR: begin
				rd_select = state_reg.bus_cycles;
			end

			perf_counter_pkg::EVENT_SELECT_ADDR: begin
				rd_select = {41'h0, state_reg.evsel};
			end

			perf_counter_pkg::GENERAL_COUNT_ADDR: begin
				rd_select = state_reg.general;
			end

			default: begin
				rd_select = 64'h0;
			end
		endcase
	end

	// Next-state logic: counting, software writes, read capture
	always_comb begin
		state_next = state_reg;

		// Retired instruction counter
		if (inst_done) begin
			state_next.retired = retired_plus; // [RULE1] [RULE18]
		end

		// Unhalted core cycle counter
		if (core_unhalted) begin
			state_next.core_cycles = core_plus; // [RULE4] [RULE18]
		end

		// Reference counter and its bus divider
		if (ref_count) begin
			state_next.ref_cycles = ref_plus; // [RULE6] [RULE18]
			state_next.ref_div    = div_next;
		end

		// Bus cycle counter
		if (bus_count) begin
			state_next.bus_cycles = bus_plus; // [RULE9]
		end

		// General counter
		if (gen_count) begin
			state_next.general = general_plus; // [RULE18]
		end

		// Software writes win over a same-cycle count
		if (wr_en && sel_retired) begin
			state_next.retired = wr_data;
		end
		if (wr_en && sel_core) begin
			state_next.core_cycles = wr_data;
		end
		if (wr_en && sel_ref) begin
			state_next.ref_cycles = wr_data;
		end
		if (wr_en && sel_bus) begin
			state_next.bus_cycles = wr_data;
		end
		if (wr_en && sel_evsel) begin
			state_next.evsel = wr_data[perf_counter_pkg::EVSEL_W-1:0];
		end
		if (wr_en && sel_general) begin
			state_next.general = wr_data;
		end

		// Read data stands only in the cycle after the strobe
		state_next.rd_data = rd_en ? rd_select : 64'h0; // [RULE18]

		// Registered copy of the enable bit for the status output
		state_next.gen_en = state_next.evsel[perf_counter_pkg::EVSEL_EN_BIT];
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// Counters clear
			state_reg.retired     <= perf_counter_pkg::CNT_RESET;
			state_reg.core_cycles <= perf_counter_pkg::CNT_RESET;
			state_reg.ref_cycles  <= perf_counter_pkg::CNT_RESET;
			state_reg.bus_cycles  <= perf_counter_pkg::CNT_RESET;
			state_reg.general     <= perf_counter_pkg::CNT_RESET;

			// Control and port registers clear
			state_reg.evsel       <= perf_counter_pkg::EVSEL_RESET;
			state_reg.ref_div     <= perf_counter_pkg::DIV_RESET;
			state_reg.rd_data     <= perf_counter_pkg::CNT_RESET;
			state_reg.gen_en      <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data         = state_reg.rd_data;
	assign general_enabled = state_reg.gen_en;

endmodule
`default_nettype wire

// ==== perf_counters_monitor.sv ====
// Port-level assertions for the performance counters
`default_nettype none
module perf_counters_monitor (
	// Watched ports
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic [11:0] addr,
	input wire logic [63:0] wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [63:0] rd_data,
	input wire logic        uop_retire,
	input wire logic        uop_is_last,
	input wire logic        core_cycle,
	input wire logic        halt_active,
	input wire logic        mwait_active,
	input wire logic        thermal_stop_clock,
	input wire logic        ref_tick,
	input wire logic        general_enabled
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	rd_idle_a: assert property (!rd_en |=> rd_data == 64'h0)
		else $error("read data not idle");
	unmapped_a: assert property (rd_en && addr == 12'h000 |=> rd_data == 64'h0)
		else $error("unmapped read not zero");
	sel_load_a: assert property (wr_en && addr == 12'h186
		|=> general_enabled == $past(wr_data[22])) else $error("enable not loaded");
	sel_hold_a: assert property (!(wr_en && addr == 12'h186)
		|=> $stable(general_enabled)) else $error("enable changed without write");
	wr_rd_a: assert property (wr_en && addr == 12'h309 ##1 rd_en && addr == 12'h309
		|=> rd_data == $past(wr_data, 2)) else $error("write not read back");
	ret_cnt_a: assert property (wr_en && addr == 12'h309 ##1 !wr_en
		##1 rd_en && addr == 12'h309
		|=> rd_data == $past(wr_data, 3) + $past(uop_retire && uop_is_last, 2))
		else $error("retired count wrong");
	core_cnt_a: assert property (wr_en && addr == 12'h30A ##1 !wr_en
		##1 rd_en && addr == 12'h30A
		|=> rd_data == $past(wr_data, 3) + $past(core_cycle && !halt_active, 2))
		else $error("core cycle count wrong");
	ref_cnt_a: assert property (wr_en && addr == 12'h30B ##1 !wr_en
		##1 rd_en && addr == 12'h30B
		|=> rd_data == $past(wr_data, 3)
		+ $past(ref_tick && !halt_active && !mwait_active && !thermal_stop_clock, 2))
		else $error("reference count wrong");
endmodule

bind perf_counters perf_counters_monitor mon (.clock(clock), .reset_n(reset_n), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.uop_retire(uop_retire), .uop_is_last(uop_is_last), .core_cycle(core_cycle),
	.halt_active(halt_active), .mwait_active(mwait_active),
	.thermal_stop_clock(thermal_stop_clock), .ref_tick(ref_tick),
	.general_enabled(general_enabled));
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the performance counters
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 0;
	logic        reset_n = 0;
	logic [11:0] addr = 12'h000;
	logic [63:0] wr_data = 64'h0;
	logic        wr_en = 0;
	logic        rd_en = 0;
	logic [13:0] ev = 14'h0000;
	logic [63:0] rd_data;
	logic        general_enabled;
	int          miscompares = 0;
	int          n_compared = 0;

	// Events travel packed in ev
	perf_counters dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .uop_retire(ev[13]),
		.uop_is_last(ev[12]), .virt_root(ev[11]), .core_cycle(ev[10]), .halt_active(ev[9]),
		.mwait_active(ev[8]), .thermal_stop_clock(ev[7]), .ref_tick(ev[6]),
		.load_wait_store_addr(ev[5]), .load_wait_store_value(ev[4]),
		.load_overlap_partial(ev[3]), .load_overlap_small_misalign(ev[2]),
		.load_overlap_wide_misalign(ev[1]), .rename_other_serial_stall(ev[0]),
		.general_enabled(general_enabled));

	// Clock, 100 ns period
	initial begin
		forever #50 clock = ~clock;
	end

	// Compare and count
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// One register port cycle
	task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [63:0] d);
		@(posedge clock);
		wr_en <= w;
		rd_en <= r;
		addr <= a;
		wr_data <= d;
	endtask
	task automatic step(input logic [13:0] v);
		bus(0, 0, 12'h000, 64'h0);
		ev <= v;
	endtask
	// Read, data checked in the following cycle
	task automatic rd(input logic [11:0] a, input logic [63:0] e);
		bus(0, 1, a, 64'h0);
		bus(0, 0, 12'h000, 64'h0);
		#1 chk($sformatf("reg %h", a), rd_data, e);
	endtask
	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Everything reads zero after reset
	task automatic t_reset();
		logic [11:0] regs [6] = '{12'h309, 12'h30A, 12'h30B, 12'h30C, 12'h186, 12'h0C1};
		chk("enable", {63'h0, general_enabled}, 64'h0);
		foreach (regs[i]) rd(regs[i], 64'h0);
	endtask
	// Cycles under halt, monitor-wait, stop-clock and a missing core tick
	task automatic t_cycles();
		logic [13:0] cyc [12] = '{14'h440, 14'h640, 14'h540, 14'h4C0, 14'h440, 14'h740,
			14'h040, 14'h440, 14'h440, 14'h440, 14'h440, 14'h440};
		foreach (cyc[i]) step(cyc[i]);
		step(14'h0000);
		rd(12'h30A, 64'h9);
		rd(12'h30B, 64'h8);
		rd(12'h30C, 64'h2);
	endtask
	// Only last micro-ops count, across the 32-bit boundary
	task automatic t_retire();
		logic [13:0] seq [7] = '{14'h2000, 14'h2000, 14'h3000, 14'h3000, 14'h1000, 14'h3000, 14'h0};
		bus(1, 0, 12'h309, 64'h00000000FFFFFFFE);
		foreach (seq[i]) step(seq[i]);
		rd(12'h309, 64'h0000000100000001);
	endtask
	// Each selectable event: {en, code, umask, strobes, expected}
	task automatic t_general();
		logic [31:0] cases [12] = '{32'h10302202, 32'h10304102, 32'h10308082, 32'h10308042,
			32'h10308022, 32'h10302100, 32'h1D210012, 32'h1C008C02, 32'h1C008400,
			32'h00302200, 32'h1030E302, 32'h1C000402};
		logic [63:0] sel;
		foreach (cases[i]) begin
			sel = {41'h0, cases[i][28], 6'h00, cases[i][19:12], cases[i][27:20]};
			bus(1, 0, 12'h186, sel);
			bus(1, 0, 12'h0C1, 64'h0);
			rd(12'h186, sel);
			chk("enable", {63'h0, general_enabled}, {63'h0, cases[i][28]});
			step({cases[i][10], cases[i][10], cases[i][11], 5'h00, cases[i][9:4]});
			step({cases[i][10], cases[i][10], cases[i][11], 5'h00, cases[i][9:4]});
			step(14'h0000);
			rd(12'h0C1, {60'h0, cases[i][3:0]});
		end
	endtask
	// Counting after load, write against event, unmapped place
	task automatic t_misc();
		logic [11:0] regs [3] = '{12'h309, 12'h30A, 12'h30B};
		foreach (regs[i]) begin
			bus(1, 0, regs[i], 64'h55);
			step(14'h3440);
			rd(regs[i], 64'h56);
			step(14'h0000);
		end
		bus(1, 0, 12'h309, 64'h10);
		ev <= 14'h3000;
		rd(12'h309, 64'h10);
		step(14'h0000);
		rd(12'h309, 64'h12);
		rd(12'h309, 64'h12);
		bus(1, 0, 12'h000, 64'hFFFFFFFFFFFFFFFF);
		rd(12'h000, 64'h0);
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1;
		t_reset();
		t_cycles();
		t_retire();
		t_general();
		t_misc();
		close_out();
	end
	// Watchdog
	initial begin
		repeat (3000) @(posedge clock);
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
